/* File: ultrasonic_system_diagnostics_tb.sv */
// Purpose: Self-checking bench for the diagnostics block
// Assumes: Shortened counts passed as parameters
// Notes: Random periods are whole 500 ns ticks so averages are exact
`timescale 1ns/1ps
module ultrasonic_system_diagnostics_tb import usd_pkg::*;;
  localparam int unsigned DGL_E = 8;
  localparam int unsigned DGL_T = 16;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, echo_level = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, prev;
  logic pready, pslverr, er, burst_active = 1'b0, objects_done = 1'b0, listen_cmd = 1'b1;
  logic [2:0] fpins = 3'h0;
  logic [1:0] cmp_mode = 2'h1;
  logic [11:0] ring_half = 12'h000;
  logic [15:0] k, a, b;
  logic exc_cmp_pin, xdcr_sig_pin, drv_enable, xdcr_drv_enable, tcl_accept;
  logic noise_run, scaling_bypass, stat_freq_err, stat_volt_err;
  int errors = 0, checks_done = 0, cyc = 0, m;
  logic [2:0] en_exp [3] = '{3'b101, 3'b110, 3'b001};
  usd_diag #(.VCHK_CYC(20), .DGL_E_CYC(DGL_E), .DGL_T_CYC(DGL_T), .NOISE_CYC(9000),
    .FSTART_CYC(10)) dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .burst_active(burst_active),
    .burst_listen_cmd(listen_cmd), .objects_done(objects_done), .echo_level(echo_level),
    .echo_valid(1'b1), .exc_cmp_pin(exc_cmp_pin), .xdcr_sig_pin(xdcr_sig_pin),
    .ov_pin(fpins[0]), .uv_pin(fpins[1]), .tsd_pin(fpins[2]), .drv_enable(drv_enable),
    .xdcr_drv_enable(xdcr_drv_enable), .tcl_accept(tcl_accept), .noise_run(noise_run),
    .scaling_bypass(scaling_bypass), .stat_freq_err(stat_freq_err),
    .stat_volt_err(stat_volt_err));
  usd_xdcr_model xdcr_u (.pclk(pclk), .burst_active(burst_active), .cmp_mode(cmp_mode),
    .ring_half(ring_half), .exc_cmp_pin(exc_cmp_pin), .xdcr_sig_pin(xdcr_sig_pin));
  initial forever #2.5 pclk = ~pclk;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, sized for about 55k cycles of tests
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(n, rd, exp);
  endtask
  // Burst, then echo above saturation for d cycles
  task automatic burst(input int d, input logic abort);
    repeat (4) @(posedge pclk);
    burst_active <= 1'b1;
    echo_level <= 8'hff;
    repeat (60) @(posedge pclk);
    burst_active <= 1'b0;
    repeat (5) @(posedge pclk);
    objects_done <= abort;
    @(posedge pclk);
    objects_done <= 1'b0;
    repeat (d - 6) @(posedge pclk);
    echo_level <= 8'h10;
    repeat (15000 - d) @(posedge pclk);
  endtask
  initial begin
    void'($urandom(42));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk("freq cfg", ADDR_FREQ_CFG, FREQ_CFG_RST);
    rchk("decay cfg", ADDR_DECAY_CFG, {24'h0, SAT_LEVEL_RST});
    rchk("unmapped", 8'h20, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      m = (i == 2) ? DGL_T : DGL_E;
      fpins[i] <= 1'b1;
      repeat (m / 2) @(posedge pclk);
      fpins[i] <= 1'b0;
      repeat (30) @(posedge pclk);
      rchk("glitch", ADDR_FAULT, 32'h0);
      fpins[i] <= 1'b1;
      repeat (m + 10) @(posedge pclk);
      chk("enables", {29'h0, drv_enable, xdcr_drv_enable, tcl_accept}, {29'h0, en_exp[i]});
      fpins[i] <= 1'b0;
      repeat (30) @(posedge pclk);
      rchk("fault", ADDR_FAULT, 32'h1 << i);
      rchk("fault cleared", ADDR_FAULT, 32'h0);
    end
    $display("test faults done");
    for (int i = 0; i < 3; i++) begin
      k = 16'd10 + 16'($urandom_range(15));
      m = 1 + $urandom_range(3);
      if (i < 2) apb(1'b1, ADDR_FREQ_CFG, {8'h00, k[7:0] + 8'(i * 5), 8'h02, 8'h11});
      cmp_mode <= 2'(i);
      ring_half <= 12'(k * 50);
      burst(m * 3200 + 1600, i == 2);
      chk("volt", {31'h0, stat_volt_err}, {31'h0, i != 0});
      rchk("decay", ADDR_DECAY_RES, 32'(m));
      if (i < 2) begin
        apb(1'b0, ADDR_FREQ_RES, 32'h0);
        prev = rd;
        chk("period", {31'h0, rd[15:0] === k || rd[15:0] === k - 16'h1}, 32'h1);
        chk("freq err", {31'h0, stat_freq_err}, 32'(i));
      end else begin
        apb(1'b1, ADDR_FREQ_RES, 32'h0000_5a5a);
        rchk("aborted", ADDR_FREQ_RES, prev);
      end
      ring_half <= 12'h000;
    end
    // A burst without the listen command must leave the voltage result alone
    listen_cmd <= 1'b0;
    cmp_mode <= 2'h0;
    burst_active <= 1'b1;
    repeat (60) @(posedge pclk);
    burst_active <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("no listen volt", {31'h0, stat_volt_err}, 32'h1);
    listen_cmd <= 1'b1;
    $display("test bursts done");
    a = 16'd16 + 16'($urandom_range(200));
    b = 16'd16 + 16'($urandom_range(200));
    echo_level <= a[7:0];
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int j = 0; j < 20 && noise_run !== 1'b1; j++) @(posedge pclk);
    rchk("busy", ADDR_CTRL, 32'h1);
    repeat ((a > b) ? 4100 : 4085) @(posedge pclk);
    echo_level <= b[7:0];
    for (int j = 0; j < 6000 && noise_run !== 1'b0; j++) @(posedge pclk);
    rchk("noise", ADDR_NOISE_RES, 32'((a > b) ? a : b));
    $display("test noise done");
    end_of_test();
  end
endmodule

/* File: usd_diag.sv */
// Purpose: Burst excitation, ringing frequency, decay, noise and supply fault diagnostics
// Assumes: burst and echo signals come from logic on pclk; comparator, transducer
//   and fault inputs are asynchronous pins
// Notes: Results hold until the next measurement of the same kind completes
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps

// Notes on behaviour
// - Comparator high before burst flags stuck failure
// - Frequency window starts after configured delay
// - Window length counted in transducer periods
// - Averaged period reported in 500 ns steps
// - Object count reached early discards frequency
// - Frequency outside band raises error status
// - Decay counted from burst end above saturation
// - Decay result unit is 16 us
// - Decay over 4 ms reads all ones
// - Noise record: listen-only preset 2, 8.192 ms
// - Two 4096-sample averages, larger one reported
// - Nonlinear scaling bypassed during noise record
// - Overvoltage, undervoltage, thermal in fault status
// - Deglitch 25 us electrical, 50 us thermal
// - Overvoltage and undervoltage bits set on detect, all fault bits clear on read
// - Overvoltage disables transducer driver only
// - Undervoltage blocks new time-command-link commands
// - Thermal fault disables drivers, sets bit after
// - Voltage check only for burst-listen, from 50 us
// - Comparator high in window means good burst
module usd_diag import usd_pkg::*; #(
  parameter int unsigned VCHK_CYC = VCHK_DELAY_CYC,
  parameter int unsigned DGL_E_CYC = DGL_ELEC_CYC,
  parameter int unsigned DGL_T_CYC = DGL_THERM_CYC,
  parameter int unsigned NOISE_CYC = NOISE_REC_CYC,
  parameter int unsigned FSTART_CYC = FSTART_UNIT_CYC
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Burst sequencer and echo data path, same clock
  input wire logic burst_active,
  input wire logic burst_listen_cmd,
  input wire logic objects_done,
  input wire logic [7:0] echo_level,
  input wire logic echo_valid,
  // Asynchronous pins
  input wire logic exc_cmp_pin,
  input wire logic xdcr_sig_pin,
  input wire logic ov_pin,
  input wire logic uv_pin,
  input wire logic tsd_pin,
  // Control outputs
  output logic drv_enable,
  output logic xdcr_drv_enable,
  output logic tcl_accept,
  output logic noise_run,
  output logic scaling_bypass,
  // Status frame bits
  output logic stat_freq_err,
  output logic stat_volt_err
);

  // Registered state and its next value
  usd_state_s s_q;
  usd_state_s s_d;

  // Deglitch length per fault lane
  function automatic logic [23:0] dgl_limit(input int unsigned lane);
    if (lane == F_TSD) begin
      dgl_limit = 24'(DGL_T_CYC - 1);
    end else begin
      dgl_limit = 24'(DGL_E_CYC - 1);
    end
  endfunction

  // Register read decode
  function automatic logic [31:0] rd_mux(input usd_state_s s, input logic [7:0] a);
    case (a)
      ADDR_CTRL: rd_mux = {31'h0, s.n_run};
      ADDR_FREQ_CFG: rd_mux = s.fcfg;
      ADDR_DECAY_CFG: rd_mux = {24'h0, s.sat_level};
      ADDR_DIAG_STAT: rd_mux = {28'h0, s.n_run, s.freq_valid, s.freq_err, s.volt_fail};
      ADDR_FREQ_RES: rd_mux = {16'h0, s.freq_result};
      ADDR_DECAY_RES: rd_mux = {24'h0, s.decay_result};
      ADDR_NOISE_RES: rd_mux = {24'h0, s.noise_result};
      ADDR_FAULT: rd_mux = {29'h0, s.fault};
      default: rd_mux = 32'h0;
    endcase
  endfunction

  // Address map check
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= ADDR_FAULT);
  endfunction

  // Next-state logic
  always_comb begin
    logic burst_start;
    logic burst_end;
    logic xdcr_rise;
    logic [2:0] fault_set;
    logic [2:0] fault_clr;
    logic [4:0] n_per;
    logic [19:0] avg0;
    logic [19:0] avg1;
    burst_start = 1'b0;
    burst_end = 1'b0;
    xdcr_rise = 1'b0;
    fault_set = 3'h0;
    fault_clr = 3'h0;
    n_per = 5'h0;
    avg0 = 20'h0;
    avg1 = 20'h0;
    s_d = s_q;

    // Two-stage synchronisers for every pin
    s_d.sync1 = {xdcr_sig_pin, exc_cmp_pin, tsd_pin, uv_pin, ov_pin};
    s_d.sync2 = s_q.sync1;

    // Edge detection: transducer pin on the second stage, burst on the direct input
    s_d.burst_prev = burst_active;
    s_d.xdcr_prev = s_q.sync2[S_XDCR];
    burst_start = burst_active && !s_q.burst_prev;
    burst_end = !burst_active && s_q.burst_prev;
    xdcr_rise = s_q.sync2[S_XDCR] && !s_q.xdcr_prev;

    for (int i = 0; i < 3; i++) begin
      if (s_q.sync2[i] != s_q.filt[i]) begin
        if (s_q.dgl_cnt[i] == dgl_limit(i)) begin
          s_d.filt[i] = s_q.sync2[i];
          s_d.dgl_cnt[i] = 24'h0;
        end else begin
          s_d.dgl_cnt[i] = s_q.dgl_cnt[i] + 24'h1;
        end
      end else begin
        s_d.dgl_cnt[i] = 24'h0;
      end
    end

    // electrical faults flag on filtered detection
    fault_set[F_OV] = s_d.filt[F_OV] && !s_q.filt[F_OV];
    fault_set[F_UV] = s_d.filt[F_UV] && !s_q.filt[F_UV];
    fault_set[F_TSD] = !s_d.filt[F_TSD] && s_q.filt[F_TSD];

    // APB setup phase captures read data and error answer
    if (psel && !penable) begin
      s_d.rdata = rd_mux(s_q, paddr);
      s_d.slverr = !addr_ok(paddr);
    end

    // APB access phase, write or clear on read
    if (psel && penable) begin
      if (pwrite && addr_ok(paddr)) begin
        case (paddr)
          ADDR_CTRL: begin
            if (pwdata[0] && !s_q.n_run && !burst_active) begin
              s_d.n_run = 1'b1;
              s_d.n_cnt = 24'h0;
              s_d.n_group = 1'b0;
              s_d.n_full = 1'b0;
              s_d.n_samp = 12'h0;
              s_d.n_sum0 = 20'h0;
              s_d.n_sum1 = 20'h0;
            end
          end
          ADDR_FREQ_CFG: s_d.fcfg = usd_fcfg_s'(pwdata);
          ADDR_DECAY_CFG: s_d.sat_level = pwdata[7:0];
          default: begin
          end
        endcase
      end else if (!pwrite && paddr == ADDR_FAULT) begin
        // only the bits actually returned are cleared
        fault_clr = s_q.rdata[2:0];
      end
    end
    // a new detection wins over the clear
    s_d.fault = (s_q.fault & ~fault_clr) | fault_set;

    // voltage check armed on burst-listen commands only
    if (burst_start && burst_listen_cmd) begin
      s_d.v_arm = 1'b1;
      s_d.v_cnt = 24'h0;
      s_d.v_seen = 1'b0;
      s_d.v_stuck = s_q.sync2[S_CMP];
    end else if (s_q.v_arm && burst_active) begin
      if (s_q.v_cnt != 24'(VCHK_CYC)) begin
        s_d.v_cnt = s_q.v_cnt + 24'h1;
      end else if (s_q.sync2[S_CMP]) begin
        s_d.v_seen = 1'b1;
      end
    end else if (s_q.v_arm && burst_end) begin
      s_d.v_arm = 1'b0;
      // no high in window is a failure
      s_d.volt_fail = s_q.v_stuck || !s_q.v_seen;
    end

    n_per = {1'b0, s_q.fcfg.window_len} + FLEN_BASE;
    case (s_q.fst)
      FS_IDLE: begin
        if (burst_end) begin
          s_d.fst = FS_DELAY;
          s_d.f_cnt = 24'h0;
        end
      end
      FS_DELAY: begin
        // wait start delay after burst completion
        if (s_q.f_cnt >= 24'(FSTART_CYC) * {20'h0, s_q.fcfg.start_delay}) begin
          s_d.fst = FS_ARM;
        end else begin
          s_d.f_cnt = s_q.f_cnt + 24'h1;
        end
      end
      FS_ARM: begin
        // First edge opens the window
        if (xdcr_rise) begin
          s_d.fst = FS_MEAS;
          s_d.f_tick = 7'h0;
          s_d.f_edges = 5'h0;
          s_d.f_total = 16'h0;
        end
      end
      FS_MEAS: begin
        // 500 ns tick counter, total saturates
        if (s_q.f_tick == 7'(TICK_CYC - 1)) begin
          s_d.f_tick = 7'h0;
          if (s_q.f_total != 16'hffff) begin
            s_d.f_total = s_q.f_total + 16'h1;
          end
        end else begin
          s_d.f_tick = s_q.f_tick + 7'h1;
        end
        // window closes after the set period count
        if (xdcr_rise) begin
          s_d.f_edges = s_q.f_edges + 5'h1;
          if (s_q.f_edges + 5'h1 == n_per) begin
            s_d.fst = FS_DIV;
            s_d.f_quot = 16'h0;
          end
        end
      end
      FS_DIV: begin
        // average by repeated subtraction; slow but small
        if (s_q.f_total >= {11'h0, n_per}) begin
          s_d.f_total = s_q.f_total - {11'h0, n_per};
          s_d.f_quot = s_q.f_quot + 16'h1;
        end else begin
          s_d.fst = FS_IDLE;
          s_d.freq_result = s_q.f_quot;
          s_d.freq_valid = 1'b1;
          // band check around the nominal period
          s_d.freq_err =
            (s_q.f_quot > {8'h0, s_q.fcfg.nominal} + {8'h0, s_q.fcfg.error_limit}) ||
            ({8'h0, s_q.fcfg.nominal} > s_q.f_quot + {8'h0, s_q.fcfg.error_limit});
        end
      end
      default: s_d.fst = FS_IDLE;
    endcase
    // objects found early discard the measurement
    if (objects_done && s_q.fst != FS_IDLE && s_q.fst != FS_DIV) begin
      s_d.fst = FS_IDLE;
    end

    // decay measured from burst end while saturated
    if (burst_end) begin
      s_d.d_run = 1'b1;
      s_d.d_pre = 12'h0;
      s_d.d_steps = 9'h0;
    end else if (s_q.d_run) begin
      if (echo_level > s_q.sat_level && s_q.d_steps <= 9'(DECAY_MAX_STEPS)) begin
        if (s_q.d_pre == 12'(DECAY_STEP_CYC - 1)) begin
          s_d.d_pre = 12'h0;
          s_d.d_steps = s_q.d_steps + 9'h1;
        end else begin
          s_d.d_pre = s_q.d_pre + 12'h1;
        end
      end else begin
        s_d.d_run = 1'b0;
        // beyond 4 ms reads all ones
        if (s_q.d_steps > 9'(DECAY_MAX_STEPS)) begin
          s_d.decay_result = DECAY_SAT_VAL;
        end else begin
          s_d.decay_result = s_q.d_steps[7:0];
        end
      end
    end

    if (s_q.n_run) begin
      // accumulate two groups of samples
      // Samples after the second group fills are ignored, each group gets all 4096
      if (echo_valid && !s_q.n_full) begin
        if (!s_q.n_group) begin
          s_d.n_sum0 = s_q.n_sum0 + {12'h0, echo_level};
        end else begin
          s_d.n_sum1 = s_q.n_sum1 + {12'h0, echo_level};
        end
        if (s_q.n_samp == NOISE_GROUP_LAST) begin
          s_d.n_samp = 12'h0;
          s_d.n_group = 1'b1;
          s_d.n_full = s_q.n_group;
        end else begin
          s_d.n_samp = s_q.n_samp + 12'h1;
        end
      end
      if (s_q.n_cnt == 24'(NOISE_CYC - 1)) begin
        s_d.n_run = 1'b0;
        avg0 = s_q.n_sum0 >> NOISE_AVG_SHIFT;
        avg1 = s_q.n_sum1 >> NOISE_AVG_SHIFT;
        s_d.noise_result = (avg0 > avg1) ? avg0[7:0] : avg1[7:0];
      end else begin
        s_d.n_cnt = s_q.n_cnt + 24'h1;
      end
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.fcfg <= usd_fcfg_s'(FREQ_CFG_RST);
      s_q.sat_level <= SAT_LEVEL_RST;
      s_q.fst <= FS_IDLE;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // APB answers in the access cycle with no wait
  assign pready = 1'b1;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.slverr && psel && penable;

  // overvoltage stops the transducer driver only
  assign xdcr_drv_enable = !s_q.filt[F_OV] && !s_q.filt[F_TSD];
  // thermal shutdown stops all output drivers
  assign drv_enable = !s_q.filt[F_TSD];
  // new command acceptance held off under undervoltage
  assign tcl_accept = !s_q.filt[F_UV];
  assign noise_run = s_q.n_run;
  // scaling bypassed while noise is recorded
  assign scaling_bypass = s_q.n_run;
  assign stat_freq_err = s_q.freq_err;
  assign stat_volt_err = s_q.volt_fail;

endmodule

/* File: usd_diag_assertions.sv */
// Purpose: Port-level checks for the diagnostics block
// Assumes: Only the top ports are visible, clk_en held high
// Notes: Pin run counters allow two sync stages of slack
`timescale 1ns/1ps
module usd_diag_checker #(
  parameter int unsigned DGL_E_CYC = 8,
  parameter int unsigned DGL_T_CYC = 16,
  parameter int unsigned NOISE_CYC = 9000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched inputs
  input wire logic ov_pin,
  input wire logic uv_pin,
  input wire logic tsd_pin,
  input wire logic burst_active,
  // Watched outputs
  input wire logic drv_enable,
  input wire logic xdcr_drv_enable,
  input wire logic tcl_accept,
  input wire logic noise_run,
  input wire logic scaling_bypass,
  input wire logic stat_volt_err,
  input wire logic stat_freq_err
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Saturating runs of pin levels
  logic [7:0] ov_run, uv_run, tsd_run, tsd_low;
  // Length of the current noise record
  logic [23:0] n_len;
  function automatic logic [7:0] step(input logic [7:0] r, input logic p);
    return p ? r + {7'h00, r != 8'hff} : 8'h00;
  endfunction
  // Run counters, cleared by reset so no stale run survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_run <= 8'h00;
      uv_run <= 8'h00;
      tsd_run <= 8'h00;
      tsd_low <= 8'h00;
      n_len <= 24'h000000;
    end else begin
      ov_run <= step(ov_run, ov_pin);
      uv_run <= step(uv_run, uv_pin);
      tsd_run <= step(tsd_run, tsd_pin);
      tsd_low <= step(tsd_low, !tsd_pin);
      n_len <= noise_run ? n_len + 24'h000001 : 24'h000000;
    end
  end
  sequence s_burst_on;
    burst_active && $past(burst_active);
  endsequence
  sequence s_noise_end;
    $fell(noise_run);
  endsequence
  property p_ov_dgl;
    $fell(xdcr_drv_enable) |-> $past(ov_run, 2) >= 8'(DGL_E_CYC - 2)
      || $past(tsd_run, 2) >= 8'(DGL_T_CYC - 2);
  endproperty
  a_ov_dgl: assert property (p_ov_dgl) else $error("driver off after short glitch");
  property p_uv_dgl;
    $fell(tcl_accept) |-> $past(uv_run, 2) >= 8'(DGL_E_CYC - 2);
  endproperty
  a_uv_dgl: assert property (p_uv_dgl) else $error("commands blocked after glitch");
  property p_tsd_dgl;
    $fell(drv_enable) |-> $past(tsd_run, 2) >= 8'(DGL_T_CYC - 2);
  endproperty
  a_tsd_dgl: assert property (p_tsd_dgl) else $error("drivers off without thermal");
  property p_tsd_rec;
    tsd_low == 8'(DGL_T_CYC + 6) |-> drv_enable && tcl_accept;
  endproperty
  a_tsd_rec: assert property (p_tsd_rec) else $error("drivers not re-enabled");
  property p_drv_pair;
    !drv_enable |-> !xdcr_drv_enable;
  endproperty
  a_drv_pair: assert property (p_drv_pair) else $error("transducer driver left on");
  property p_bypass;
    scaling_bypass == noise_run;
  endproperty
  a_bypass: assert property (p_bypass) else $error("scaling bypass mismatch");
  property p_noise_len;
    s_noise_end |-> n_len == 24'(NOISE_CYC);
  endproperty
  a_noise_len: assert property (p_noise_len) else $error("noise record length off");
  property p_noise_quiet;
    $rose(noise_run) |-> !burst_active;
  endproperty
  a_noise_quiet: assert property (p_noise_quiet) else $error("noise record in burst");
  property p_volt_hold;
    s_burst_on |-> $stable(stat_volt_err) && $stable(stat_freq_err);
  endproperty
  a_volt_hold: assert property (p_volt_hold) else $error("status moved in burst");
endmodule

bind usd_diag usd_diag_checker #(.DGL_E_CYC(DGL_E_CYC), .DGL_T_CYC(DGL_T_CYC),
  .NOISE_CYC(NOISE_CYC)) u_chk (.pclk(pclk), .presetn(presetn), .ov_pin(ov_pin),
  .uv_pin(uv_pin), .tsd_pin(tsd_pin), .burst_active(burst_active),
  .drv_enable(drv_enable), .xdcr_drv_enable(xdcr_drv_enable), .tcl_accept(tcl_accept),
  .noise_run(noise_run), .scaling_bypass(scaling_bypass),
  .stat_volt_err(stat_volt_err), .stat_freq_err(stat_freq_err));

/* File: usd_pkg.sv */
// Purpose: Shared constants, types and register map for the ultrasonic diagnostics block
// Assumes: 200 MHz core clock, APB register access with 32-bit data
// Notes: Long cycle counts appear here as defaults of top-level parameters
package usd_pkg;

  // Clock period
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Frequency measurement time base, one step is 500 ns
  localparam int unsigned TICK_NS = 500;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  // Unit of the start delay setting, 100 us per count
  localparam int unsigned FSTART_UNIT_NS = 100000;
  localparam int unsigned FSTART_UNIT_CYC = FSTART_UNIT_NS / CLK_PERIOD_NS;
  // Window length setting 0 means this many periods
  localparam logic [4:0] FLEN_BASE = 5'h02;

  // Decay time step of 16 us and 4 ms saturation point
  localparam int unsigned DECAY_STEP_NS = 16000;
  localparam int unsigned DECAY_STEP_CYC = DECAY_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned DECAY_LIMIT_NS = 4000000;
  localparam int unsigned DECAY_MAX_STEPS = DECAY_LIMIT_NS / DECAY_STEP_NS;
  localparam logic [7:0] DECAY_SAT_VAL = 8'hff;

  // Voltage check opens 50 us after burst start
  localparam int unsigned VCHK_DELAY_NS = 50000;
  localparam int unsigned VCHK_DELAY_CYC = VCHK_DELAY_NS / CLK_PERIOD_NS;

  // Fault deglitch times
  localparam int unsigned DGL_ELEC_NS = 25000;
  localparam int unsigned DGL_ELEC_CYC = DGL_ELEC_NS / CLK_PERIOD_NS;
  localparam int unsigned DGL_THERM_NS = 50000;
  localparam int unsigned DGL_THERM_CYC = DGL_THERM_NS / CLK_PERIOD_NS;

  // Noise record of 8.192 ms, two groups of 4096 samples
  localparam int unsigned NOISE_REC_NS = 8192000;
  localparam int unsigned NOISE_REC_CYC = NOISE_REC_NS / CLK_PERIOD_NS;
  localparam logic [11:0] NOISE_GROUP_LAST = 12'hfff;
  localparam int unsigned NOISE_AVG_SHIFT = 12;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FREQ_CFG = 8'h04;
  localparam logic [7:0] ADDR_DECAY_CFG = 8'h08;
  localparam logic [7:0] ADDR_DIAG_STAT = 8'h0c;
  localparam logic [7:0] ADDR_FREQ_RES = 8'h10;
  localparam logic [7:0] ADDR_DECAY_RES = 8'h14;
  localparam logic [7:0] ADDR_NOISE_RES = 8'h18;
  localparam logic [7:0] ADDR_FAULT = 8'h1c;

  // Reset values of the configuration registers
  localparam logic [31:0] FREQ_CFG_RST = 32'h0022_0a00;
  localparam logic [7:0] SAT_LEVEL_RST = 8'h80;

  // Fault bit positions, also synchroniser lanes
  localparam int unsigned F_OV = 0;
  localparam int unsigned F_UV = 1;
  localparam int unsigned F_TSD = 2;
  localparam int unsigned S_CMP = 3;
  localparam int unsigned S_XDCR = 4;

  // Frequency measurement sequence
  typedef enum logic [2:0] {
    FS_IDLE, FS_DELAY, FS_ARM, FS_MEAS, FS_DIV
  } usd_fstate_e;

  // Configuration fields of the frequency setup register
  typedef struct packed {
    logic [7:0] unused;
    logic [7:0] nominal;
    logic [7:0] error_limit;
    logic [3:0] window_len;
    logic [3:0] start_delay;
  } usd_fcfg_s;

  // Whole state of the diagnostics module
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [2:0][23:0] dgl_cnt;
    logic [2:0] filt;
    logic [2:0] fault;
    usd_fcfg_s fcfg;
    logic [7:0] sat_level;
    logic [31:0] rdata;
    logic slverr;
    logic burst_prev;
    logic xdcr_prev;
    logic v_arm;
    logic v_stuck;
    logic v_seen;
    logic [23:0] v_cnt;
    logic volt_fail;
    usd_fstate_e fst;
    logic [23:0] f_cnt;
    logic [6:0] f_tick;
    logic [4:0] f_edges;
    logic [15:0] f_total;
    logic [15:0] f_quot;
    logic [15:0] freq_result;
    logic freq_valid;
    logic freq_err;
    logic d_run;
    logic [11:0] d_pre;
    logic [8:0] d_steps;
    logic [7:0] decay_result;
    logic n_run;
    logic [23:0] n_cnt;
    logic n_group;
    logic n_full;
    logic [11:0] n_samp;
    logic [19:0] n_sum0;
    logic [19:0] n_sum1;
    logic [7:0] noise_result;
  } usd_state_s;

endpackage

/* File: usd_xdcr_model.sv */
// Purpose: Transducer node and excitation comparator facing the block
// Assumes: Ringing half period in core cycles, zero means silent
// Notes: A silent node sits low; mode 1 models a weak drive
`timescale 1ns/1ps
module usd_xdcr_model (
  // Clock
  input wire logic pclk,
  // Controls from the bench
  input wire logic burst_active,
  input wire logic [1:0] cmp_mode,
  input wire logic [11:0] ring_half,
  // Pins toward the block
  output logic exc_cmp_pin,
  output logic xdcr_sig_pin
);
  logic [11:0] rc = 12'h000; // Ringing phase
  logic [7:0] bcnt = 8'h00; // Cycles into the burst
  logic sig = 1'b0; // Node level
  // Ringing waveform and burst age
  always @(posedge pclk) begin
    bcnt <= burst_active ? bcnt + {7'h00, bcnt != 8'hff} : 8'h00;
    if (ring_half == 12'h000) begin
      rc <= 12'h000;
      sig <= 1'b0;
    end else if (rc + 12'h001 >= ring_half) begin
      rc <= 12'h000;
      sig <= !sig;
    end else begin
      rc <= rc + 12'h001;
    end
  end
  assign xdcr_sig_pin = sig;
  // Mode 0 rises late in the burst, mode 2 is stuck high
  assign exc_cmp_pin = (cmp_mode == 2'h2) || (cmp_mode == 2'h0 && bcnt >= 8'h1e);
endmodule
